// *** core/rtcopc_pkg.sv ***
// Function
// [RULE1] Kilohertz pin runs 32.768kHz, 50% duty, only with khz_out_enable.
// [RULE2] Enabled kilohertz output keeps running on primary or battery supply.
// [RULE3] interrupt_select 0 puts a 1Hz square wave on the multifunction pin.
// [RULE4] interrupt_select 1 pulls the pin low on an enabled alarm match.
// [RULE5] Power-up sets interrupt_select to 1 with both alarms disabled.
// [RULE6] Reset pin held low while primary supply is under threshold.
// [RULE7] Once supply recovers, reset stays low a hold time, then is released.
// [RULE8] Reset pin is a debounced pushbutton input; a press asserts reset.
// [RULE9] Oscillator disabled: hold time is skipped, reset released at once.
// [RULE10] Pins are pull-down enables; hold, debounce counts are parameters.
package rtcopc_pkg;
  localparam logic [7:0] OUTCFG_OFFSET   = 8'h0E;
  localparam logic [7:0] FLAG_OFFSET     = 8'h0F;
  localparam int         OUTCFG_A1E_BIT  = 0;
  localparam int         OUTCFG_A2E_BIT  = 1;
  localparam int         OUTCFG_ISEL_BIT = 2;
  localparam int         OUTCFG_OSCD_BIT = 7;
  localparam int         FLAG_A1F_BIT    = 0;
  localparam int         FLAG_A2F_BIT    = 1;
  localparam int         FLAG_KHZ_BIT    = 3;
  localparam logic [7:0] OUTCFG_RESET    = 8'h1C;
  localparam logic [7:0] FLAG_RESET      = 8'h08;
  localparam logic [7:0] OUTCFG_WMASK    = 8'hFF;
  localparam logic [7:0] FLAG_WMASK      = 8'h08;
  localparam int         CLK_HZ          = 250000000;
  localparam int         KHZ_HZ          = 32768;
  // Half period of the kilohertz output in cycles, rounded down
  localparam int         KHZ_HALF_CYC    = CLK_HZ / (2 * KHZ_HZ);
  localparam int         HOLD_MS         = 250;
  localparam int         DEBOUNCE_MS     = 250;
  localparam longint     HOLD_CYC        = longint'(CLK_HZ) / 1000 * HOLD_MS;
  localparam longint     DEBOUNCE_CYC    =
    longint'(CLK_HZ) / 1000 * DEBOUNCE_MS;
  typedef enum logic [1:0] {
    RTCOPC_IDLE,
    RTCOPC_FAIL,
    RTCOPC_HOLD,
    RTCOPC_PRESS
  } rtcopc_rst_t;
endpackage

// *** core/rtcopc_regs.sv ***
module rtcopc_regs (
  input  wire logic       mclk,      // Clock
  input  wire logic       reset,     // Sync reset
  input  wire logic       wr_en,     // Register write strobe
  input  wire logic       rd_en,     // Register read strobe
  input  wire logic [7:0] addr,      // Register offset
  input  wire logic [7:0] wdata,     // Write data
  input  wire logic [1:0] flag_set,  // Alarm flag set pulses
  output logic      [7:0] rdata,     // Registered read data
  output logic      [7:0] outcfg,    // Output config register
  output logic      [7:0] flags      // Flag register
);
  logic [7:0] outcfg_r;
  logic [7:0] flag_r;
  logic [7:0] rdata_r;
  logic [7:0] flag_nxt;

  always_comb begin
    flag_nxt = flag_r;
    if (wr_en && addr == rtcopc_pkg::FLAG_OFFSET) begin
      // Alarm flags clear on written zero; khz enable is plain storage
      flag_nxt = (flag_r & (wdata | rtcopc_pkg::FLAG_WMASK))
               & ~rtcopc_pkg::FLAG_WMASK;
      flag_nxt = flag_nxt | (wdata & rtcopc_pkg::FLAG_WMASK);
    end
    // Set beats clear so a match in the clearing cycle is kept
    flag_nxt[rtcopc_pkg::FLAG_A1F_BIT] =
      flag_nxt[rtcopc_pkg::FLAG_A1F_BIT] | flag_set[0];
    flag_nxt[rtcopc_pkg::FLAG_A2F_BIT] =
      flag_nxt[rtcopc_pkg::FLAG_A2F_BIT] | flag_set[1];
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      outcfg_r <= rtcopc_pkg::OUTCFG_RESET; // [RULE5]
    end else if (wr_en && addr == rtcopc_pkg::OUTCFG_OFFSET) begin
      outcfg_r <= wdata & rtcopc_pkg::OUTCFG_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flag_r <= rtcopc_pkg::FLAG_RESET;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (rd_en) begin
      if (addr == rtcopc_pkg::OUTCFG_OFFSET) begin
        rdata_r <= outcfg_r;
      end else if (addr == rtcopc_pkg::FLAG_OFFSET) begin
        rdata_r <= flag_r;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign rdata  = rdata_r;
  assign outcfg = outcfg_r;
  assign flags  = flag_r;
endmodule // rtcopc_regs

// *** core/rtcopc_top.sv ***
module rtcopc_top #(
  parameter longint HOLD_CYC     = rtcopc_pkg::HOLD_CYC,     // Reset hold
  parameter longint DEBOUNCE_CYC = rtcopc_pkg::DEBOUNCE_CYC, // Debounce
  parameter int     KHZ_HALF     = rtcopc_pkg::KHZ_HALF_CYC, // Khz half
  parameter int     SEC_HALF_CYC = rtcopc_pkg::CLK_HZ / 2    // 1Hz half
) (
  input  wire logic       mclk,                  // Clock
  input  wire logic       reset,                 // Sync reset, high
  input  wire logic       reg_wr,                // Register write strobe
  input  wire logic       reg_rd,                // Register read strobe
  input  wire logic [7:0] reg_addr,              // Register offset
  input  wire logic [7:0] reg_wdata,             // Write data
  output logic      [7:0] reg_rdata,             // Read data
  input  wire logic [1:0] alarm_match,           // Alarm match pulses
  input  wire logic       power_fail_threshold,  // High: supply below trip
  input  wire logic       rst_pin_in,            // Reset pin level
  output logic            rst_pin_oe,            // Reset pin pull-down
  output logic            kilohertz_clock_out,   // Khz pin pull-down
  output logic            alarm_or_tick_out_n,   // Multifunction pull-down
  output logic            reset_active           // Reset asserted state
);
  logic [7:0] outcfg;
  logic [7:0] flags;
  logic [7:0] rdata_w;
  logic [1:0] flag_set;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  rtcopc_regs u_regs (
    .mclk     (mclk),
    .reset    (reset),
    .wr_en    (reg_wr),
    .rd_en    (reg_rd),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .flag_set (flag_set),
    .rdata    (rdata_w),
    .outcfg   (outcfg),
    .flags    (flags)
  );
  assign reg_rdata = rdata_w;

  logic a1e;
  logic a2e;
  logic isel;
  logic oscd;
  logic khz_en;
  assign a1e    = outcfg[rtcopc_pkg::OUTCFG_A1E_BIT];
  assign a2e    = outcfg[rtcopc_pkg::OUTCFG_A2E_BIT];
  assign isel   = outcfg[rtcopc_pkg::OUTCFG_ISEL_BIT];
  assign oscd   = outcfg[rtcopc_pkg::OUTCFG_OSCD_BIT];
  assign khz_en = flags[rtcopc_pkg::FLAG_KHZ_BIT];
  assign flag_set = alarm_match;

  ////////////////////////////////////////////////////////////////////////////
  // Kilohertz output; no supply input gates it, so it runs on battery too
  logic [15:0] khz_cnt_r;
  logic        khz_ph_r;
  logic        khz_out_r;
  always_ff @(posedge mclk) begin
    if (reset || !khz_en) begin
      khz_cnt_r <= 16'h0000;
      khz_ph_r  <= 1'b0;
    end else if (khz_cnt_r == 16'(KHZ_HALF - 1)) begin
      khz_cnt_r <= 16'h0000;
      khz_ph_r  <= ~khz_ph_r; // [RULE1] [RULE2]
    end else begin
      khz_cnt_r <= khz_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      khz_out_r <= 1'b0;
    end else begin
      // Pull down only during low half; disabled leaves pin released
      khz_out_r <= khz_en && !khz_ph_r; // [RULE1] [RULE10]
    end
  end
  assign kilohertz_clock_out = khz_out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Multifunction output
  logic [27:0] sec_cnt_r;
  logic        sec_ph_r;
  logic        mf_out_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sec_cnt_r <= 28'h0000000;
      sec_ph_r  <= 1'b0;
    end else if (sec_cnt_r == 28'(SEC_HALF_CYC - 1)) begin
      sec_cnt_r <= 28'h0000000;
      sec_ph_r  <= ~sec_ph_r;
    end else begin
      sec_cnt_r <= sec_cnt_r + 28'h0000001;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      mf_out_r <= 1'b0;
    end else if (!isel) begin
      mf_out_r <= !sec_ph_r; // [RULE3] [RULE10]
    end else begin
      mf_out_r <= (a1e && flags[rtcopc_pkg::FLAG_A1F_BIT])
               || (a2e && flags[rtcopc_pkg::FLAG_A2F_BIT]); // [RULE4]
    end
  end
  assign alarm_or_tick_out_n = mf_out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Reset supervisor
  rtcopc_pkg::rtcopc_rst_t st_r;
  logic [35:0] hold_cnt_r;
  logic [35:0] db_cnt_r;
  logic        rst_oe_r;
  logic        press_ok;
  // Press valid once pin seen low by others for the debounce time
  assign press_ok = (db_cnt_r == 36'(DEBOUNCE_CYC)); // [RULE8]

  always_ff @(posedge mclk) begin
    if (reset || rst_oe_r || rst_pin_in) begin
      db_cnt_r <= 36'h000000000;
    end else if (!press_ok) begin
      db_cnt_r <= db_cnt_r + 36'h000000001; // [RULE8]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r       <= rtcopc_pkg::RTCOPC_FAIL;
      hold_cnt_r <= 36'h000000000;
    end else begin
      case (st_r)
        rtcopc_pkg::RTCOPC_IDLE: begin
          hold_cnt_r <= 36'h000000000;
          if (power_fail_threshold) begin
            st_r <= rtcopc_pkg::RTCOPC_FAIL; // [RULE6]
          end else if (press_ok) begin
            st_r <= rtcopc_pkg::RTCOPC_PRESS; // [RULE8]
          end
        end
        rtcopc_pkg::RTCOPC_FAIL: begin
          hold_cnt_r <= 36'h000000000;
          if (!power_fail_threshold) begin
            // No recovery delay while the oscillator is stopped
            st_r <= oscd ? rtcopc_pkg::RTCOPC_IDLE
                         : rtcopc_pkg::RTCOPC_HOLD; // [RULE9] [RULE7]
          end
        end
        rtcopc_pkg::RTCOPC_HOLD, rtcopc_pkg::RTCOPC_PRESS: begin
          if (power_fail_threshold) begin
            st_r <= rtcopc_pkg::RTCOPC_FAIL;
          end else if (oscd || hold_cnt_r == 36'(HOLD_CYC - 1)) begin
            st_r <= rtcopc_pkg::RTCOPC_IDLE; // [RULE7] [RULE9]
          end else begin
            hold_cnt_r <= hold_cnt_r + 36'h000000001;
          end
        end
        default: st_r <= rtcopc_pkg::RTCOPC_FAIL;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rst_oe_r <= 1'b1;
    end else begin
      rst_oe_r <= (st_r != rtcopc_pkg::RTCOPC_IDLE)
                  || power_fail_threshold; // [RULE6] [RULE10]
    end
  end
  assign rst_pin_oe   = rst_oe_r;
  assign reset_active = rst_oe_r;
endmodule // rtcopc_top

// *** tb/rtcopc_properties.sv ***
module rtcopc_properties #(
  parameter int KHZ_HALF = 4 // Khz half period
) (
  input wire logic       mclk,                 // Clock
  input wire logic       reset,                // Sync reset
  input wire logic       reg_wr,               // Write strobe
  input wire logic [7:0] reg_addr,             // Offset
  input wire logic [7:0] reg_wdata,            // Write data
  input wire logic [1:0] alarm_match,          // Match pulses
  input wire logic       power_fail_threshold, // Supply low
  input wire logic       rst_pin_in,           // Reset wire
  input wire logic       rst_pin_oe,           // Reset pull-down
  input wire logic       kilohertz_clock_out,  // Khz pull-down
  input wire logic       alarm_or_tick_out_n,  // Multifunction
  input wire logic       reset_active          // Reset state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [7:0] cfg_r;
  logic       khz_en_r;
  logic       prev_r;
  logic [7:0] run_r;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of written bits; writes are the only way these change
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_r    <= rtcopc_pkg::OUTCFG_RESET;
      khz_en_r <= 1'b1;
    end else if (reg_wr && reg_addr == rtcopc_pkg::OUTCFG_OFFSET) begin
      cfg_r <= reg_wdata;
    end else if (reg_wr && reg_addr == rtcopc_pkg::FLAG_OFFSET) begin
      khz_en_r <= reg_wdata[rtcopc_pkg::FLAG_KHZ_BIT];
    end
  end
  always_ff @(posedge mclk) begin
    prev_r <= kilohertz_clock_out;
    run_r  <= (kilohertz_clock_out != prev_r) ? 8'h01 : run_r + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  fail_forces_a: assert property (
    power_fail_threshold |=> rst_pin_oe)
    else $error("reset not driven during power fail");
  state_mirror_a: assert property (
    reset_active == rst_pin_oe)
    else $error("reset state differs from pin enable");
  hold_min_a: assert property (
    $fell(power_fail_threshold) && !cfg_r[rtcopc_pkg::OUTCFG_OSCD_BIT]
    |=> rst_pin_oe [*8])
    else $error("reset released before hold time");
  osc_bypass_a: assert property (
    $fell(power_fail_threshold) && cfg_r[rtcopc_pkg::OUTCFG_OSCD_BIT]
    |-> ##[1:4] !rst_pin_oe)
    else $error("reset not released at once");
  khz_off_a: assert property (
    !khz_en_r |=> !kilohertz_clock_out)
    else $error("khz output runs while disabled");
  khz_duty_a: assert property (
    disable iff (reset || !khz_en_r)
    $fell(kilohertz_clock_out) |-> run_r == KHZ_HALF)
    else $error("khz low phase length wrong");
  alarm_out_a: assert property (
    cfg_r[rtcopc_pkg::OUTCFG_ISEL_BIT] && |(alarm_match & cfg_r[1:0])
    |-> ##2 alarm_or_tick_out_n)
    else $error("enabled alarm did not assert output");
  press_deb_a: assert property (
    $rose(rst_pin_oe) && !power_fail_threshold
    && !$past(power_fail_threshold) |-> !$past(rst_pin_in, 8))
    else $error("press accepted before debounce");
  cover property ($rose(alarm_or_tick_out_n));
  cover property ($rose(rst_pin_oe) && !power_fail_threshold);
  cover property ($fell(kilohertz_clock_out) && khz_en_r);
endmodule // rtcopc_properties

bind rtcopc_top rtcopc_properties #(.KHZ_HALF(KHZ_HALF)) u_props (
  .mclk, .reset, .reg_wr, .reg_addr, .reg_wdata, .alarm_match,
  .power_fail_threshold, .rst_pin_in, .rst_pin_oe, .kilohertz_clock_out,
  .alarm_or_tick_out_n, .reset_active);

// *** tb/rtcopc_reset_line.sv ***
module rtcopc_reset_line (
  input  wire logic press,      // Pushbutton closed
  input  wire logic rst_pin_oe, // Device pull-down
  output wire logic rst_pin_in  // Resolved wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins only when neither the button nor the device pulls low
  assign rst_pin_in = !(rst_pin_oe || press);
endmodule // rtcopc_reset_line

// *** tb/rtcopc_tb_top.sv ***
module rtcopc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HC = 20, DB = 10, KH = 4, SH = 50;
  logic mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, pf = 1, press = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic [1:0] am = 2'h0;
  logic rst_pin_in, rst_pin_oe, khz, mf, reset_active;
  int num_errors = 0, samples_checked = 0, cyc = 0, n;
  initial forever #2 mclk = ~mclk;
  rtcopc_top #(.HOLD_CYC(HC), .DEBOUNCE_CYC(DB), .KHZ_HALF(KH),
    .SEC_HALF_CYC(SH)) DUT (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .alarm_match(am), .power_fail_threshold(pf),
    .rst_pin_in(rst_pin_in), .rst_pin_oe(rst_pin_oe),
    .kilohertz_clock_out(khz), .alarm_or_tick_out_n(mf),
    .reset_active(reset_active));
  rtcopc_reset_line u_line (.press(press), .rst_pin_oe(rst_pin_oe),
    .rst_pin_in(rst_pin_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(negedge mclk) reg_wr = 0;
    // Idle cycle so a following call never re-raises the strobe at once
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd = 1; reg_addr = a;
    @(negedge mclk) reg_rd = 0;
    d = reg_rdata;
    @(negedge mclk);
  endtask
  // Length of one full phase of a pin, bounded so a stuck pin cannot hang
  task automatic phase(input bit sel, output int c);
    logic s;
    c = 0;
    s = sel ? mf : khz;
    while ((sel ? mf : khz) === s && c < 300) begin @(negedge mclk); c++; end
    s = sel ? mf : khz;
    c = 0;
    while ((sel ? mf : khz) === s && c < 300) begin @(negedge mclk); c++; end
  endtask
  task automatic oe_wait(input logic l, output int c);
    c = 0;
    while (rst_pin_oe !== l && c < 300) begin @(negedge mclk); c++; end
  endtask
  task automatic pulse(input int i);
    am = 2'(1 << i);
    @(negedge mclk) am = 2'h0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin num_errors++; print_verdict(); end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge mclk);
    reset = 0;
    rd(8'h0E, v); chk("outcfg", 8'h1C, v);
    rd(8'h0F, v); chk("flags", 8'h08, v);
    rd(8'h33, v); chk("unmapped", 8'h00, v);
    chk("fail_rst", 1, reset_active);
    phase(0, n); chk("khz_batt", KH, n);
    pf = 0;
    oe_wait(0, n); chk("hold", 1, n >= HC && n <= HC + 3);
    phase(0, n); chk("khz_half", KH, n);
    wr(8'h0F, 8'h00); repeat (3) @(negedge mclk);
    chk("khz_off", 0, khz);
    for (int i = 0; i < 2; i++) begin
      pulse(i); chk("alarm_masked", 0, mf);
      wr(8'h0F, 8'h00); wr(8'h0E, 8'h1C | 8'(1 << i));
      pulse(i); chk("alarm_on", 1, mf);
      rd(8'h0F, v); chk("flag_set", 8'(1 << i), v);
      wr(8'h0F, 8'h00); repeat (2) @(negedge mclk);
      chk("alarm_clr", 0, mf);
      wr(8'h0E, 8'h1C);
    end
    wr(8'h0E, 8'h00);
    // Mode switch is on the pin before wr returns; first change seen is a tick boundary
    phase(1, n);
    phase(1, n); chk("tick_half", SH, n);
    wr(8'h0E, 8'h80); pf = 1; repeat (3) @(negedge mclk);
    chk("pf_oe", 1, rst_pin_oe);
    pf = 0; oe_wait(0, n); chk("osc_bypass", 1, n <= 4);
    wr(8'h0E, 8'h1C); press = 1; repeat (DB - 4) @(negedge mclk);
    press = 0; repeat (3) @(negedge mclk);
    chk("short_press", 0, rst_pin_oe);
    press = 1; oe_wait(1, n); chk("debounce", 1, n >= DB && n <= DB + 4);
    press = 0; oe_wait(0, n); chk("press_hold", 1, n >= HC - 4 && n <= HC + 3);
    print_verdict();
  end
endmodule // rtcopc_tb_top
